/* rtl/usart_clk_frame.sv */
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module usart_clk_frame (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // transfer clock pin
  input wire logic XCK_I,
  output logic XCK_O,
  output logic XCK_OE_O,
  // frame data and status
  input wire logic [8:0] TX_CHAR_I,
  input wire logic [8:0] RX_CHAR_I,
  input wire logic RX_FIRST_STOP_I,
  output logic TX_BIT_TICK_O,
  output logic RX_SAMPLE_TICK_O,
  output logic SYNC_SHIFT_O,
  output logic SYNC_SAMPLE_O,
  output logic TX_PARITY_O,
  output logic RX_PARITY_OK_O,
  output logic FRAME_ERROR_O,
  output logic [3:0] DATA_BITS_O,
  output logic TWO_STOPS_O,
  output logic PARITY_EN_O
);
  // configuration state
  logic [11:0] baud_divisor; // full twelve-bit divisor
  logic double_speed_sel;
  logic xfer_clock_direction; // 1: master drives pin
  logic sync_mode_sel;
  logic clock_polarity_sel;
  logic [2:0] char_size_sel;
  logic [1:0] parity_mode_sel;
  logic stop_bits_sel;
  logic ninth_data_bit;
  logic [11:0] baud_count; // down-counter
  logic baud_tick; // one-cycle pulse at zero
  logic [3:0] tx_div; // transmit divider
  logic [3:0] rx_state; // recovery state counter
  logic [3:0] ratio; // selected ratio minus one
  logic xck_sync1, xck_sync2, xck_prev; // slave synchroniser and edge memory
  logic xck_rise, xck_fall;
  logic xck_int; // master-generated clock
  logic bus_ack; // single wait cycle before answer
  logic low_write, ctrl_c_write, div_high_write, ctrl_a_write;
  logic is_master, is_slave;
  logic [8:0] data_mask;
  logic [31:0] next_readdata; // read mux ahead of the output register

  // bus strobes: one wait cycle, then answer
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~bus_ack;
  assign low_write = AVS_WRITE_I & bus_ack & (AVS_ADDRESS_I == usart_clk_pkg::OFS_DIV_LOW);
  assign ctrl_c_write = AVS_WRITE_I & bus_ack & (AVS_ADDRESS_I == usart_clk_pkg::OFS_CTRL_C)
                        & AVS_WRITEDATA_I[usart_clk_pkg::REG_SELECT_BIT];
  assign div_high_write = AVS_WRITE_I & bus_ack & (AVS_ADDRESS_I == usart_clk_pkg::OFS_CTRL_C)
                          & ~AVS_WRITEDATA_I[usart_clk_pkg::REG_SELECT_BIT];
  assign ctrl_a_write = AVS_WRITE_I & bus_ack & (AVS_ADDRESS_I == usart_clk_pkg::OFS_CTRL_A);

  // acknowledge toggles so each request gets exactly one wait cycle
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (AVS_READ_I | AVS_WRITE_I) & ~bus_ack;
    end
  end

  // divisor registers, twelve bits split low byte and high nibble
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      baud_divisor <= usart_clk_pkg::DIV_RESET;
    end else if (low_write) begin
      baud_divisor[7:0] <= AVS_WRITEDATA_I[7:0];
    end else if (div_high_write) begin
      baud_divisor[11:8] <= AVS_WRITEDATA_I[3:0];
    end
  end

  // control c: mode, frame format and polarity, shared by both directions
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sync_mode_sel <= 1'b0;
      parity_mode_sel <= usart_clk_pkg::PAR_NONE;
      stop_bits_sel <= 1'b0;
      char_size_sel <= usart_clk_pkg::CSZ_RESET;
      clock_polarity_sel <= 1'b0;
    end else if (ctrl_c_write) begin
      // no guard against mid-frame change; software must wait for idle
      sync_mode_sel <= AVS_WRITEDATA_I[usart_clk_pkg::SYNC_MODE_BIT];
      parity_mode_sel <= AVS_WRITEDATA_I[usart_clk_pkg::PARITY_HI_BIT:
                                         usart_clk_pkg::PARITY_LO_BIT];
      stop_bits_sel <= AVS_WRITEDATA_I[usart_clk_pkg::STOP_BITS_BIT];
      char_size_sel <= AVS_WRITEDATA_I[usart_clk_pkg::CSZ_HI_BIT:usart_clk_pkg::CSZ_LO_BIT];
      clock_polarity_sel <= AVS_WRITEDATA_I[usart_clk_pkg::CLK_POL_BIT];
    end
  end

  // control a: double speed, pin direction, ninth data bit source
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      double_speed_sel <= 1'b0;
      xfer_clock_direction <= 1'b0;
      ninth_data_bit <= 1'b0;
    end else if (ctrl_a_write) begin
      double_speed_sel <= AVS_WRITEDATA_I[usart_clk_pkg::DOUBLE_SPEED_BIT];
      xfer_clock_direction <= AVS_WRITEDATA_I[usart_clk_pkg::XCK_DIR_BIT];
      ninth_data_bit <= AVS_WRITEDATA_I[usart_clk_pkg::NINTH_BIT_BIT];
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      usart_clk_pkg::OFS_DIV_LOW: next_readdata[7:0] = baud_divisor[7:0];
      usart_clk_pkg::OFS_CTRL_C: next_readdata[15:0] = {7'h00, clock_polarity_sel, 1'b1,
        sync_mode_sel, parity_mode_sel, stop_bits_sel, char_size_sel};
      usart_clk_pkg::OFS_CTRL_A: next_readdata[2:0] = {ninth_data_bit, double_speed_sel,
        xfer_clock_direction};
      usart_clk_pkg::OFS_STATUS: next_readdata[19:0] = {rx_state, baud_count, tx_div};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, so it stands while the answer is taken
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (AVS_READ_I & ~bus_ack) begin
      AVS_READDATA_O <= next_readdata;
    end
  end

  assign is_master = sync_mode_sel & xfer_clock_direction;
  assign is_slave = sync_mode_sel & ~xfer_clock_direction;

  // down-counter: reload at zero or on low-byte write
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      baud_count <= usart_clk_pkg::DIV_RESET;
    end else if (low_write) begin
      baud_count <= {baud_divisor[11:8], AVS_WRITEDATA_I[7:0]};
    end else if (baud_count == 12'h000) begin
      baud_count <= baud_divisor;
    end else begin
      baud_count <= baud_count - 12'h001;
    end
  end
  // tick every divisor+1 cycles
  assign baud_tick = (baud_count == 12'h000) & ~low_write;

  // ratio per mode; double speed ignored in sync mode
  always_comb begin
    if (sync_mode_sel) begin
      ratio = usart_clk_pkg::RATIO_SYNC;
    end else if (double_speed_sel) begin
      ratio = usart_clk_pkg::RATIO_DOUBLE;
    end else begin
      ratio = usart_clk_pkg::RATIO_NORMAL;
    end
  end

  // transmit divider, counts baud ticks up to the ratio
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_div <= 4'h0;
    end else if (baud_tick) begin
      tx_div <= (tx_div >= ratio) ? 4'h0 : tx_div + 4'h1;
    end
  end

  // receiver recovery state counter on undivided ticks
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_state <= 4'h0;
    end else if (baud_tick) begin
      rx_state <= (rx_state >= ratio) ? 4'h0 : rx_state + 4'h1;
    end
  end

  // master clock level: toggles each tick, idles at polarity level
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      xck_int <= 1'b0;
    end else if (!is_master) begin
      xck_int <= clock_polarity_sel;
    end else if (baud_tick) begin
      xck_int <= ~xck_int;
    end
  end

  // slave synchroniser then edge detector, two cycle latency
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      xck_sync1 <= 1'b0;
      xck_sync2 <= 1'b0;
      xck_prev <= 1'b0;
    end else begin
      xck_sync1 <= XCK_I;
      xck_sync2 <= xck_sync1;
      xck_prev <= xck_sync2;
    end
  end
  assign xck_rise = xck_sync2 & ~xck_prev;
  assign xck_fall = ~xck_sync2 & xck_prev;

  // pin drive only in master sync mode
  assign XCK_O = xck_int;
  assign XCK_OE_O = is_master;

  // bit ticks and sync change/sample strobes
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TX_BIT_TICK_O <= 1'b0;
      RX_SAMPLE_TICK_O <= 1'b0;
      SYNC_SHIFT_O <= 1'b0;
      SYNC_SAMPLE_O <= 1'b0;
    end else begin
      TX_BIT_TICK_O <= is_slave ? 1'b0 : baud_tick & (tx_div >= ratio);
      RX_SAMPLE_TICK_O <= is_slave ? 1'b0 : baud_tick;
      if (is_master) begin
        // master: edge about to be produced on this tick
        SYNC_SHIFT_O <= baud_tick & (xck_int == clock_polarity_sel);
        SYNC_SAMPLE_O <= baud_tick & (xck_int != clock_polarity_sel);
      end else if (is_slave) begin
        SYNC_SHIFT_O <= clock_polarity_sel ? xck_fall : xck_rise;
        SYNC_SAMPLE_O <= clock_polarity_sel ? xck_rise : xck_fall;
      end else begin
        SYNC_SHIFT_O <= 1'b0;
        SYNC_SAMPLE_O <= 1'b0;
      end
    end
  end

  // frame format decode
  always_comb begin
    case (char_size_sel)
      usart_clk_pkg::CSZ_5: DATA_BITS_O = 4'h5;
      usart_clk_pkg::CSZ_6: DATA_BITS_O = 4'h6;
      usart_clk_pkg::CSZ_7: DATA_BITS_O = 4'h7;
      usart_clk_pkg::CSZ_8: DATA_BITS_O = 4'h8;
      usart_clk_pkg::CSZ_9: DATA_BITS_O = 4'h9;
      default: DATA_BITS_O = 4'h8; // reserved codes behave as eight
    endcase
  end
  assign TWO_STOPS_O = stop_bits_sel;
  assign PARITY_EN_O = parity_mode_sel[1];

  // mask of valid data bits, lsb first
  for (genvar gi = 0; gi < 9; gi++) begin : g_mask
    assign data_mask[gi] = (4'(gi) < DATA_BITS_O);
  end

  // parity and stop check, registered
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TX_PARITY_O <= 1'b0;
      RX_PARITY_OK_O <= 1'b0;
      FRAME_ERROR_O <= 1'b0;
    end else begin
      TX_PARITY_O <= ^({ninth_data_bit, TX_CHAR_I[7:0]} & data_mask)
                     ^ (parity_mode_sel == usart_clk_pkg::PAR_ODD);
      // no parity bit arrives here: high when the masked data xor matches the mode
      RX_PARITY_OK_O <= ~(^(RX_CHAR_I & data_mask) ^
                        (parity_mode_sel == usart_clk_pkg::PAR_ODD));
      FRAME_ERROR_O <= ~RX_FIRST_STOP_I;
    end
  end

  // assertions
  // zero count reloads the old divisor, even if the high nibble moves now
  a_baud_reload: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (baud_count == 12'h000 && !low_write) |=> baud_count == $past(baud_divisor))
    else $error("counter did not reload at zero");
  // a low byte write restarts the count from the new divisor at once
  a_low_restart: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    low_write |=> baud_count == baud_divisor)
    else $error("low byte write did not restart count");
  // ticks only at zero
  a_tick_zero: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    baud_tick |-> baud_count == 12'h000)
    else $error("tick without zero count");
  // sync modes divide by two whatever double speed says
  a_ratio_sync: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    sync_mode_sel |-> ratio == usart_clk_pkg::RATIO_SYNC)
    else $error("sync ratio wrong");
  // double speed only in async mode
  a_ratio_double: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!sync_mode_sel && double_speed_sel) |-> ratio == usart_clk_pkg::RATIO_DOUBLE)
    else $error("double speed ratio wrong");
  // transmit divider wraps at the ratio, also after a ratio cut
  a_tx_wrap: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (baud_tick && tx_div >= ratio) |=> tx_div == 4'h0)
    else $error("transmit divider did not wrap");
  // recovery counter wraps the same way on undivided ticks
  a_rx_wrap: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (baud_tick && rx_state >= ratio) |=> rx_state == 4'h0)
    else $error("recovery state did not wrap");
  // slave pin edges seen after the synchroniser, mode settled
  sequence s_xck_edge;
    is_slave && $stable(is_slave) && $rose(xck_sync2);
  endsequence
  a_slave_delay: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    s_xck_edge ##0 !clock_polarity_sel |=> SYNC_SHIFT_O)
    else $error("slave shift strobe missing");
  sequence s_xck_fall;
    is_slave && $stable(is_slave) && $fell(xck_sync2);
  endsequence
  // falling pin edge is the sample edge with polarity cleared
  a_slave_sample: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    s_xck_fall ##0 !clock_polarity_sel |=> SYNC_SAMPLE_O)
    else $error("slave sample strobe missing");
  // master ticks with the mode settled
  sequence s_master_tick;
    is_master && $stable(is_master) && baud_tick;
  endsequence
  a_master_toggle: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    s_master_tick |=> XCK_O != $past(XCK_O))
    else $error("master clock did not toggle");
  // outside master mode the clock parks at the polarity level
  a_master_idle: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !is_master |=> XCK_O == $past(clock_polarity_sel))
    else $error("clock not parked at polarity level");
  // pin driven only by a sync master
  a_pin_drive: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    XCK_OE_O == (sync_mode_sel && xfer_clock_direction))
    else $error("pin direction wrong");
  // async mode never produces sync strobes
  a_sync_gate: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !sync_mode_sel |=> !SYNC_SHIFT_O && !SYNC_SAMPLE_O)
    else $error("sync strobe in async mode");
  // low first stop bit flags the frame
  a_frame_error: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !RX_FIRST_STOP_I |=> FRAME_ERROR_O)
    else $error("frame error not raised");
  // high first stop bit keeps the flag down, second stop never looked at
  a_frame_ok: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    RX_FIRST_STOP_I |=> !FRAME_ERROR_O)
    else $error("frame error without bad stop bit");
  // change and sample never on the same edge
  a_opposite_edges: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !(SYNC_SHIFT_O && SYNC_SAMPLE_O))
    else $error("shift and sample on same edge");
endmodule

/* pkg/usart_clk_pkg.sv */
package usart_clk_pkg;
  // register byte offsets (one 32-bit word each)
  localparam logic [3:0] OFS_DIV_LOW = 4'h0; // baud divisor bits 7:0, write reloads
  localparam logic [3:0] OFS_CTRL_C = 4'h4; // shared: divisor high or control c
  localparam logic [3:0] OFS_CTRL_A = 4'h8; // control a: double speed, pin direction, ninth data bit
  localparam logic [3:0] OFS_STATUS = 4'hC; // block state, read only
  // control c field positions
  localparam int REG_SELECT_BIT = 7;
  localparam int SYNC_MODE_BIT = 6;
  localparam int PARITY_HI_BIT = 5;
  localparam int PARITY_LO_BIT = 4;
  localparam int STOP_BITS_BIT = 3;
  localparam int CSZ_HI_BIT = 2;
  localparam int CSZ_LO_BIT = 0;
  localparam int CLK_POL_BIT = 8;
  // control a field positions
  localparam int DOUBLE_SPEED_BIT = 1;
  localparam int XCK_DIR_BIT = 0;
  localparam int NINTH_BIT_BIT = 2;
  // divisor layout
  localparam int DIV_WIDTH = 12;
  localparam int DIV_HI_BITS = 4;
  // reset values
  localparam logic [11:0] DIV_RESET = 12'h000;
  localparam logic [2:0] CSZ_RESET = 3'h3;
  // character size codes
  localparam logic [2:0] CSZ_5 = 3'h0;
  localparam logic [2:0] CSZ_6 = 3'h1;
  localparam logic [2:0] CSZ_7 = 3'h2;
  localparam logic [2:0] CSZ_8 = 3'h3;
  localparam logic [2:0] CSZ_9 = 3'h7;
  // parity modes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  // divide ratios and recovery state counts
  localparam logic [3:0] RATIO_NORMAL = 4'hF; // 16 minus one
  localparam logic [3:0] RATIO_DOUBLE = 4'h7; // 8 minus one
  localparam logic [3:0] RATIO_SYNC = 4'h1; // 2 minus one
  // clock timing
  localparam int CLK_HZ = 10000000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int SLAVE_DELAY_CYCLES = 2; // sync register plus edge detector
endpackage

/* testbench/xck_master_model.sv */
`timescale 1ns/1ps
// far-side clock master for synchronous slave runs
module xck_master_model #(
  parameter int HALF = 3 // half period in system cycles
) (
  // system clock
  input wire logic clk_i,
  // bench control
  input wire logic run_i,
  input wire logic idle_i,
  // clock to the pin
  output logic xck_o
);
  int cnt; // cycles spent in the current half period
  initial xck_o = 1'b0;
  // parks at the idle level between frames, no free-running clock
  // a half period of 3 gives a sixth of the system rate, under the quarter limit
  always @(posedge clk_i) begin
    if (!run_i) begin
      xck_o <= idle_i;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      xck_o <= ~xck_o;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

/* testbench/usart_clk_frame_tb_top.sv */
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module usart_clk_frame_tb_top;
  localparam int LIMIT = 20000; // longest scenario is well under this
  // bench side of the ports
  logic clk, rst_n, read, write, waitreq, xck, xck_o, xck_oe, first_stop, run, idle;
  logic tx_tick, rx_tick, shift, sample, tx_par, rx_par_ok, frame_err, two_stops, par_en;
  logic [3:0] address, data_bits;
  logic [31:0] wdata, rdata, rd;
  logic [8:0] tx_char, rx_char;
  int err_total = 0; // mismatches
  int total_checks = 0; // comparisons made
  int cycles = 0; // hang guard
  int n; // measured cycle counts
  // test tables
  logic [8:0] chars [4] = '{9'h0A5, 9'h1FF, 9'h000, 9'h13E};
  logic [2:0] sizes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
  logic [3:0] widths [6] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h8};
  logic [1:0] pars [3] = '{2'h0, 2'h2, 2'h3};
  usart_clk_frame i_usart_clk_frame (
    .CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(address), .AVS_READ_I(read),
    .AVS_WRITE_I(write), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .XCK_I(xck), .XCK_O(xck_o), .XCK_OE_O(xck_oe),
    .TX_CHAR_I(tx_char), .RX_CHAR_I(rx_char), .RX_FIRST_STOP_I(first_stop),
    .TX_BIT_TICK_O(tx_tick), .RX_SAMPLE_TICK_O(rx_tick), .SYNC_SHIFT_O(shift),
    .SYNC_SAMPLE_O(sample), .TX_PARITY_O(tx_par), .RX_PARITY_OK_O(rx_par_ok),
    .FRAME_ERROR_O(frame_err), .DATA_BITS_O(data_bits), .TWO_STOPS_O(two_stops),
    .PARITY_EN_O(par_en));
  xck_master_model i_xck_master_model (.clk_i(clk), .run_i(run), .idle_i(idle), .xck_o(xck));
  // system clock
  initial begin
    clk = 1'b0;
    forever #(usart_clk_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one bus cycle: request held until waitrequest is sampled low, data taken at that edge
  task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    address <= a;
    wdata <= d;
    write <= wr_en;
    read <= !wr_en;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // control c always written with the select bit set
  task automatic cfg(input logic sync, input logic [1:0] par, input logic stop,
                     input logic [2:0] size, input logic pol);
    wr(usart_clk_pkg::OFS_CTRL_C, {23'h0, pol, 1'b1, sync, par, stop, size});
  endtask
  // high nibble first, low byte last so the reload sees the whole value
  task automatic set_div(input logic [11:0] d);
    wr(usart_clk_pkg::OFS_CTRL_C, {28'h0, d[11:8]});
    wr(usart_clk_pkg::OFS_DIV_LOW, {24'h0, d[7:0]});
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return rx_tick;
      1: return tx_tick;
      2: return shift;
      default: return sample;
    endcase
  endfunction
  // cycles between two pulses; the first pulse after a change is skipped
  task automatic gap(input int s, output int cnt);
    cnt = 0;
    repeat (2) begin
      do @(negedge clk); while (pick(s) !== 1'b1);
    end
    do begin
      @(negedge clk);
      cnt++;
    end while (pick(s) !== 1'b1);
  endtask
  // cycles from a pin edge to the given level until the pulse appears
  task automatic latency(input int s, input logic lvl, output int cnt);
    logic prev;
    cnt = 0;
    @(negedge clk);
    prev = xck;
    forever begin
      @(negedge clk);
      if (xck === lvl && prev !== lvl) break;
      prev = xck;
    end
    while (pick(s) !== 1'b1 && cnt < 20) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  initial begin
    rst_n = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    wdata = 32'h0;
    tx_char = 9'h000;
    rx_char = 9'h000;
    first_stop = 1'b1;
    run = 1'b0;
    idle = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHECK_EQ(data_bits, 4'h8)
    `CHECK_EQ(xck_oe, 1'b0)
    gap(0, n);
    `CHECK_EQ(n, 1)
    bus(1'b0, 4'h2, 32'h0, rd);
    `CHECK_EQ(rd, 32'h0000_0000)
    bus(1'b0, usart_clk_pkg::OFS_CTRL_C, 32'h0, rd);
    `CHECK_EQ(rd, 32'h0000_0083)
    // rates in the three internal clock modes
    set_div(12'h003);
    gap(0, n);
    `CHECK_EQ(n, 4)
    gap(1, n);
    `CHECK_EQ(n, 64)
    wr(usart_clk_pkg::OFS_CTRL_A, 32'h2);
    gap(1, n);
    `CHECK_EQ(n, 32)
    wr(usart_clk_pkg::OFS_CTRL_A, 32'h1);
    cfg(1'b1, usart_clk_pkg::PAR_NONE, 1'b0, usart_clk_pkg::CSZ_8, 1'b0);
    @(negedge clk);
    `CHECK_EQ(xck_oe, 1'b1)
    gap(1, n);
    `CHECK_EQ(n, 8)
    gap(2, n);
    `CHECK_EQ(n, 8)
    `CHECK_EQ(xck_o, 1'b1)
    // back to async, full twelve-bit divisor
    cfg(1'b0, usart_clk_pkg::PAR_NONE, 1'b0, usart_clk_pkg::CSZ_8, 1'b0);
    wr(usart_clk_pkg::OFS_CTRL_A, 32'h0);
    set_div(12'h103);
    gap(0, n);
    `CHECK_EQ(n, 260)
    // low byte write restarts the count at once instead of waiting out 256
    set_div(12'h0FF);
    wr(usart_clk_pkg::OFS_DIV_LOW, 32'h2);
    n = 0;
    while (rx_tick !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    `CHECK_EQ(n, 4)
    gap(0, n);
    `CHECK_EQ(n, 3)
    // every named size code plus reserved code 4, every parity mode and stop count
    for (int i = 0; i < 6; i++) begin
      cfg(1'b0, pars[i % 3], i[0], sizes[i], 1'b0);
      @(negedge clk);
      `CHECK_EQ(data_bits, widths[i])
      `CHECK_EQ(par_en, pars[i % 3] != usart_clk_pkg::PAR_NONE)
      `CHECK_EQ(two_stops, i[0])
    end
    // parity over the active data bits only, upper bits ignored
    for (int s = 0; s < 2; s++) begin
      for (int p = 1; p < 3; p++) begin
        cfg(1'b0, pars[p], 1'b0, s ? usart_clk_pkg::CSZ_8 : usart_clk_pkg::CSZ_5, 1'b0);
        for (int c = 0; c < 4; c++) begin
          @(posedge clk);
          tx_char <= chars[c];
          rx_char <= chars[c];
          repeat (3) @(negedge clk);
          `CHECK_EQ(tx_par, ^(chars[c] & (s ? 9'h0FF : 9'h01F)) ^ (p == 2))
          `CHECK_EQ(rx_par_ok, !(^(chars[c] & (s ? 9'h0FF : 9'h01F)) ^ (p == 2)))
        end
      end
    end
    // nine-bit transmit characters take the ninth bit from control a, not the data
    wr(usart_clk_pkg::OFS_CTRL_A, 32'h4);
    cfg(1'b0, usart_clk_pkg::PAR_EVEN, 1'b0, usart_clk_pkg::CSZ_9, 1'b0);
    @(posedge clk);
    tx_char <= 9'h000;
    repeat (3) @(negedge clk);
    `CHECK_EQ(tx_par, 1'b1)
    wr(usart_clk_pkg::OFS_CTRL_A, 32'h0);
    // only the first stop bit decides a frame error
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      first_stop <= k[0];
      repeat (2) @(negedge clk);
      `CHECK_EQ(frame_err, !k[0])
    end
    // slave: external clock, both polarities
    for (int pol = 0; pol < 2; pol++) begin
      // pin parks at the new idle level before the mode changes
      @(posedge clk);
      idle <= pol[0];
      cfg(1'b1, usart_clk_pkg::PAR_NONE, 1'b0, usart_clk_pkg::CSZ_8, pol[0]);
      @(posedge clk);
      run <= 1'b1;
      @(negedge clk);
      `CHECK_EQ(xck_oe, 1'b0)
      latency(2, !pol[0], n);
      `CHECK_EQ(n, 1 + usart_clk_pkg::SLAVE_DELAY_CYCLES)
      latency(3, pol[0], n);
      `CHECK_EQ(n, 1 + usart_clk_pkg::SLAVE_DELAY_CYCLES)
      @(posedge clk);
      run <= 1'b0;
    end
    tally_and_finish();
  end
endmodule
